// ### verilog/sct_pkg.sv
// Purpose: Shared constants and carriers for the converter timing controller
// Assumes: APB register access, 32-bit data, one clock
// Notes:   Offsets are byte addresses
package sct_pkg;

   localparam int unsigned SCT_AW = 8;
   localparam int unsigned SCT_RES_W = 14;

   localparam logic [7:0] SCT_OFS_CTRL   = 8'h00;
   localparam logic [7:0] SCT_OFS_RESULT = 8'h88;
   localparam logic [7:0] SCT_OFS_CFG    = 8'ha4;

   localparam int unsigned SCT_CTRL_START  = 0;
   localparam int unsigned SCT_CFG_SELFPD  = 21;
   localparam int unsigned SCT_CFG_DISCH   = 20;
   localparam int unsigned SCT_CFG_SET_HI  = 19;
   localparam int unsigned SCT_CFG_SET_LO  = 17;
   localparam int unsigned SCT_CFG_CLK_HI  = 15;
   localparam int unsigned SCT_CFG_CLK_LO  = 12;
   localparam int unsigned SCT_CFG_W       = 22;

   // selfpd=1, discharge=1, settle=5, clock=7, highres=1
   localparam logic [21:0] SCT_CFG_RESET    = 22'h3b_7010;
   localparam logic [21:0] SCT_CFG_WMASK    = 22'h3f_ffff;
   localparam logic [13:0] SCT_RESULT_RESET = 14'h0000;

   // Base tracking window in converter clock cycles
   localparam logic [8:0] SCT_BASE_TRACK = 9'h004;

   typedef enum logic [2:0] {
      SCT_IDLE  = 3'b000,
      SCT_DISCH = 3'b001,
      SCT_TRACK = 3'b010,
      SCT_CONV  = 3'b011,
      SCT_DONE  = 3'b100
   } sctState_t;

   typedef struct packed {
      logic [SCT_AW-1:0] paddr;
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [31:0]       pwdata;
   } sctApbReq_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } sctApbRsp_t;

   typedef struct packed {
      logic powerDown;
      logic discharge;
      logic track;
      logic convert;
   } sctCoreCtl_t;

   // Extra sampling cycles added to the base window
   function automatic logic [8:0] sctExtraCycles(input logic [2:0] code);
      logic [8:0] r;
      r = 9'h000;
      case (code)
         3'd0:    r = 9'h000;
         3'd1:    r = 9'h004;
         3'd2:    r = 9'h008;
         3'd3:    r = 9'h010;
         3'd4:    r = 9'h020;
         3'd5:    r = 9'h040;
         3'd6:    r = 9'h080;
         default: r = 9'h100;
      endcase
      return r;
   endfunction

endpackage

// ### verilog/sct_tick_gen.sv
// Purpose: Converter clock enable from the system clock
// Assumes: Setting N gives one tick every 2*(N+1) system cycles
// Notes:   Counter restarts on reset only; a new setting applies at once to the count in progress
`timescale 1ns/1ps
`default_nettype none
module sct_tick_gen
   import sct_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [3:0] divSel,
   output logic            tick
);

   typedef struct packed {
      logic [4:0] cnt;
      logic       tick;
   } sctTickState_t;

   sctTickState_t s_q;
   sctTickState_t s_d;
   logic [4:0]    lastCnt;

   always_comb begin
      lastCnt = {divSel, 1'b1};
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt >= lastCnt) begin
         s_d.cnt = 5'h00;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule
`default_nettype wire

// ### verilog/sct_converter_ctrl.sv
// Purpose: Timing, power and result control for a SAR converter core
// Assumes: Core raises a done level after convert rises, drops it after convert falls
// Notes:   Core done and result cross in through two flip-flops
`timescale 1ns/1ps
`default_nettype none

module sct_converter_ctrl
   import sct_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 srst,
   input  wire sctApbReq_t           apbReq,
   output sctApbRsp_t                apbRsp,
   output sctCoreCtl_t               coreCtl,
   input  wire logic                 coreDone,
   input  wire logic [SCT_RES_W-1:0] coreResult,
   output logic                      busy
);

   typedef struct packed {
      sctState_t            state;
      logic [8:0]           trackLeft;
      logic                 start;
      logic [SCT_CFG_W-1:0] cfg;
      logic [SCT_RES_W-1:0] result;
      logic                 done1;
      logic                 done2;
      logic                 doneSeen;
      logic [SCT_RES_W-1:0] res1;
      logic [SCT_RES_W-1:0] res2;
      logic [31:0]          prdata;
      logic                 pslverr;
      sctCoreCtl_t          ctl;
   } sctCtrlState_t;

   sctCtrlState_t s_q;
   sctCtrlState_t s_d;
   logic          tick;
   logic          setupPhase;
   logic          writeNow;
   logic          mapped;
   logic          selfPd;
   logic          dischEn;
   logic [8:0]    trackLen;

   sct_tick_gen u_tick (
      .clk    (clk),
      .srst   (srst),
      .divSel (s_q.cfg[SCT_CFG_CLK_HI:SCT_CFG_CLK_LO]),
      .tick   (tick)
   );

   assign selfPd   = s_q.cfg[SCT_CFG_SELFPD];
   assign dischEn  = s_q.cfg[SCT_CFG_DISCH];
   assign trackLen = SCT_BASE_TRACK
                   + sctExtraCycles(s_q.cfg[SCT_CFG_SET_HI:SCT_CFG_SET_LO]);

   assign setupPhase = apbReq.psel && !apbReq.penable;
   assign writeNow   = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign mapped     = (apbReq.paddr == SCT_OFS_CTRL)
                    || (apbReq.paddr == SCT_OFS_RESULT)
                    || (apbReq.paddr == SCT_OFS_CFG);

   always_comb begin
      s_d = s_q;

      // Synchroniser stage two reads only stage one
      s_d.done1 = coreDone;
      s_d.done2 = s_q.done1;
      s_d.res1  = coreResult;
      s_d.res2  = s_q.res1;

      // Read data captured in setup so the access phase answers from flops
      if (setupPhase) begin
         s_d.pslverr = !mapped;
         case (apbReq.paddr)
            SCT_OFS_CTRL:   s_d.prdata = {31'h0000_0000, s_q.start};
            SCT_OFS_RESULT: s_d.prdata = {18'h0_0000, s_q.result};
            SCT_OFS_CFG:    s_d.prdata = {10'h000, s_q.cfg};
            default:        s_d.prdata = 32'h0000_0000;
         endcase
      end

      // Clear before the write so a start landing on the finishing edge wins
      if (s_q.state == SCT_CONV && s_q.done2 && !s_q.doneSeen) begin
         s_d.start = 1'b0;
      end

      if (writeNow) begin
         if (apbReq.paddr == SCT_OFS_CFG) begin
            s_d.cfg = apbReq.pwdata[SCT_CFG_W-1:0] & SCT_CFG_WMASK;
         end
         // A start while busy is absorbed: the bit already reads one
         if (apbReq.paddr == SCT_OFS_CTRL && apbReq.pwdata[SCT_CTRL_START]) begin
            s_d.start = 1'b1;
         end
      end

      case (s_q.state)
         SCT_IDLE: begin
            if (s_q.start && tick) begin
               if (dischEn) begin
                  s_d.state = SCT_DISCH;
               end else begin
                  s_d.state = SCT_TRACK;
                  s_d.trackLeft = trackLen;
               end
            end
         end
         SCT_DISCH: begin
            if (tick) begin
               s_d.state = SCT_TRACK;
               s_d.trackLeft = trackLen;
            end
         end
         SCT_TRACK: begin
            if (tick) begin
               if (s_q.trackLeft <= 9'h001) begin
                  s_d.state = SCT_CONV;
                  s_d.trackLeft = 9'h000;
               end else begin
                  s_d.trackLeft = s_q.trackLeft - 9'h001;
               end
            end
         end
         SCT_CONV: begin
            if (s_q.done2 && !s_q.doneSeen) begin
               s_d.result = s_q.res2;
               s_d.state = SCT_DONE;
            end
         end
         SCT_DONE: begin
            // Wait for the core to drop done so one conversion latches once
            if (!s_q.done2) begin
               s_d.state = SCT_IDLE;
            end
         end
         default: begin
            s_d.state = SCT_IDLE;
         end
      endcase

      s_d.doneSeen = s_q.done2;

      s_d.ctl.powerDown = selfPd && (s_d.state == SCT_IDLE);
      s_d.ctl.discharge = (s_d.state == SCT_DISCH);
      s_d.ctl.track     = (s_d.state == SCT_TRACK);
      s_d.ctl.convert   = (s_d.state == SCT_CONV);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q           <= '0;
         s_q.state     <= SCT_IDLE;
         s_q.cfg       <= SCT_CFG_RESET;
         s_q.result    <= SCT_RESULT_RESET;
         s_q.ctl.powerDown <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign apbRsp.prdata  = s_q.prdata;
   assign apbRsp.pslverr = s_q.pslverr && apbReq.psel && apbReq.penable;
   assign apbRsp.pready  = apbReq.psel && apbReq.penable;
   assign coreCtl        = s_q.ctl;
   assign busy           = s_q.start;

endmodule
`default_nettype wire

// ### dv/sct_core_model.sv
// Purpose: Behavioural SAR core beside the controller
// Assumes: Convert is a level held until done is seen
// Notes:   Off-window result is inverted
`timescale 1ns/1ps
`default_nettype none
module sct_core_model
   import sct_pkg::*;
(
   input  wire logic                 clk,
   input  wire sctCoreCtl_t          coreCtl,
   input  wire logic [SCT_RES_W-1:0] value,
   output logic                      coreDone,
   output logic [SCT_RES_W-1:0]      coreResult
);
   logic [2:0] cnt = 3'h0;
   initial coreDone = 1'b0;
   initial coreResult = 14'h0000;
   // Done held until convert drops
   always @(posedge clk) begin
      cnt <= coreCtl.convert ? cnt + {2'h0, cnt != 3'h4} : 3'h0;
      coreDone <= coreCtl.convert && cnt == 3'h4;
      // Stale samples show up as wrong codes
      coreResult <= (coreCtl.convert && cnt >= 3'h2) || coreDone ? value : ~value;
   end
endmodule
`default_nettype wire

// ### dv/sct_converter_ctrl_asserts.sv
// Purpose: Port assertions for the converter controller
// Assumes: Core done follows convert
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module sct_converter_ctrl_asserts
   import sct_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire sctApbReq_t  apbReq,
   input wire sctApbRsp_t  apbRsp,
   input wire sctCoreCtl_t coreCtl,
   input wire logic        coreDone,
   input wire logic        busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   wire logic phase = coreCtl.discharge | coreCtl.track | coreCtl.convert;
   sequence s_disch_end;
      coreCtl.discharge ##1 !coreCtl.discharge;
   endsequence
   a_pready_zero: assert property (apbReq.psel && apbReq.penable |-> apbRsp.pready)
      else $error("pready late");
   a_err_access: assert property (apbRsp.pslverr |-> apbReq.psel && apbReq.penable)
      else $error("stray pslverr");
   a_disch_track: assert property (s_disch_end |-> coreCtl.track)
      else $error("no track after discharge");
   a_awake_phase: assert property (phase |-> !coreCtl.powerDown)
      else $error("powered down in phase");
   a_one_phase: assert property ($onehot0({coreCtl.discharge, coreCtl.track, coreCtl.convert}))
      else $error("phases overlap");
   a_phase_busy: assert property (phase |-> busy)
      else $error("phase while idle");
   a_conv_hold: assert property (coreCtl.convert && !coreDone |=> coreCtl.convert)
      else $error("convert dropped early");
   a_done_end: assert property ($rose(coreDone) |-> ##[1:4] !busy)
      else $error("busy stuck");
   a_track_min: assert property ($rose(coreCtl.track) |-> coreCtl.track [*8])
      else $error("track too short");
   a_reset_state: assert property (disable iff (1'b0) srst |=> coreCtl.powerDown && !busy)
      else $error("bad reset state");
endmodule
bind sct_converter_ctrl sct_converter_ctrl_asserts u_chk (.clk(clk), .srst(srst),
   .apbReq(apbReq), .apbRsp(apbRsp), .coreCtl(coreCtl), .coreDone(coreDone), .busy(busy));
`default_nettype wire

// ### dv/sct_converter_ctrl_tb.sv
// Purpose: Self-checking bench for the converter controller
// Assumes: Divider code 0 gives a tick every 2 clocks
// Notes:   Rows sweep all window codes
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin err_total++; \
   $display("[ERR] %0t got %h want %h", $time, x, y); end end
module sct_converter_ctrl_tb
   import sct_pkg::*;
;
   typedef struct packed {logic [4:0] cf; logic [13:0] v; logic [9:0] t;} sctRow_t;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   sctApbReq_t  apbReq = '0;
   sctApbRsp_t  apbRsp;
   sctCoreCtl_t coreCtl;
   logic        coreDone, busy, rerr, bPrev = 1'b0;
   logic [13:0] coreResult, value = 14'h0000;
   logic [31:0] rdat;
   int          err_total = 0, comparisons = 0, dCnt = 0, tCnt = 0, i;
   // {selfpd, discharge, code}, result, track clocks
   // Windows kept short for run time; real software keeps 64 us with selfpd
   sctRow_t rows [8] = '{'{5'h18, 14'h0000, 10'h008}, '{5'h09, 14'h3fff, 10'h010},
      '{5'h12, 14'h1555, 10'h018}, '{5'h03, 14'h2aaa, 10'h028}, '{5'h1c, 14'h0001, 10'h048},
      '{5'h0d, 14'h3ffe, 10'h088}, '{5'h16, 14'h0f0f, 10'h108}, '{5'h07, 14'h30c3, 10'h208}};
   always #2 clk = ~clk;
   always @(posedge clk) begin
      bPrev <= busy;
      dCnt <= (busy && !bPrev) ? 0 : dCnt + int'(coreCtl.discharge);
      tCnt <= (busy && !bPrev) ? 0 : tCnt + int'(coreCtl.track);
   end
   sct_converter_ctrl u_dut (.clk(clk), .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp),
      .coreCtl(coreCtl), .coreDone(coreDone), .coreResult(coreResult), .busy(busy));
   sct_core_model u_core (.clk(clk), .coreCtl(coreCtl), .value(value), .coreDone(coreDone),
      .coreResult(coreResult));
   task automatic close_out;
      $display("errors %0d checks %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      apbReq <= '{a, 1'b1, 1'b0, w, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (apbRsp.pready === 1'b1) break;
      end
      rdat = apbRsp.prdata;
      rerr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      if (n == 16) begin
         `CHK(1'b1, 1'b0)
         close_out();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(a, 1'b0, 32'h0000_0000);
      `CHK(rdat, x)
   endtask
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rd(SCT_OFS_CFG, 32'h003b_7010);
      rd(SCT_OFS_RESULT, 32'h0000_0000);
      foreach (rows[k]) begin
         value <= rows[k].v;
         apb(SCT_OFS_CFG, 1'b1, {10'h000, rows[k].cf, 17'h0_0010});
         apb(SCT_OFS_CTRL, 1'b1, 32'h0000_0001);
         rd(SCT_OFS_CTRL, 32'h0000_0001);
         for (i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
         `CHK(busy, 1'b0)
         if (i == 2000) close_out();
         `CHK(dCnt, rows[k].cf[3] ? 2 : 0)
         `CHK(tCnt, int'(rows[k].t))
         rd(SCT_OFS_RESULT, {18'h0_0000, rows[k].v});
         for (i = 0; i < 8 && coreCtl.powerDown !== rows[k].cf[4]; i++) @(posedge clk);
         `CHK(coreCtl.powerDown, rows[k].cf[4])
      end
      // Read-only result must ignore writes
      apb(SCT_OFS_RESULT, 1'b1, 32'h0000_1234);
      rd(SCT_OFS_RESULT, 32'h0000_30c3);
      apb(8'h10, 1'b0, 32'h0000_0000);
      `CHK(rerr, 1'b1)
      apb(SCT_OFS_CTRL, 1'b1, 32'h0000_0001);
      for (i = 0; i < 40 && coreCtl.track !== 1'b1; i++) @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      `CHK({busy, coreCtl.powerDown}, 2'h1)
      rd(SCT_OFS_RESULT, 32'h0000_0000);
      close_out();
   end
endmodule
`default_nettype wire
